// ==== rtl/arw_pkg.sv ====
package arw_pkg;
  // ----------------------------------------------------------------------
  // Register map, byte addresses on the plain register port.
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_COMMAND    = 8'h0a; // Conversion mode field lives here.
  localparam logic [7:0] ADDR_CTRLF      = 8'h09; // Accumulation count and left align.
  localparam logic [7:0] ADDR_INPUT_SEL  = 8'h0c; // Positive input select.
  localparam logic [7:0] ADDR_STATUS     = 8'h0d; // Window and settling status.
  localparam logic [7:0] ADDR_CONV_L     = 8'h10; // Conversion value, low byte.
  localparam logic [7:0] ADDR_CONV_H     = 8'h11; // Conversion value, high byte.
  localparam logic [7:0] ADDR_LATEST_L   = 8'h14; // Latest sample, low byte.
  localparam logic [7:0] ADDR_LATEST_H   = 8'h15; // Latest sample, high byte.
  localparam logic [7:0] ADDR_STAGING    = 8'h18; // Shared byte staging.
  localparam logic [7:0] ADDR_WLOW_L     = 8'h1c; // Window low limit, low byte.
  localparam logic [7:0] ADDR_WLOW_H     = 8'h1d; // Window low limit, high byte.
  localparam logic [7:0] ADDR_WHIGH_L    = 8'h1e; // Window high limit, low byte.
  localparam logic [7:0] ADDR_WHIGH_H    = 8'h1f; // Window high limit, high byte.

  // ----------------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------------
  localparam int         MODE_LSB        = 4;     // Mode field bits 6:4 of command.
  localparam int         LEFT_ALIGN_BIT  = 4;     // Left align bit in control F.
  localparam logic [2:0] MODE_ACC_DIAG   = 3'h7;  // Accumulator diagnostics mode code.
  localparam logic [2:0] MODE_SINGLE8    = 3'h0;  // Single 8-bit mode code.
  localparam logic [2:0] MODE_SINGLE10   = 3'h1;  // Single 10-bit mode code.
  localparam logic [15:0] RESET_WORD     = 16'h0000; // Reset of every 16-bit register.
  localparam logic [7:0]  RESET_BYTE     = 8'h00;    // Reset of every byte register.

  // ----------------------------------------------------------------------
  // Positive input select codes.
  // ----------------------------------------------------------------------
  localparam logic [6:0] SEL_PIN_LOW_LO  = 7'h00;
  localparam logic [6:0] SEL_PIN_LOW_HI  = 7'h07;
  localparam logic [6:0] SEL_PIN_HIGH_LO = 7'h10;
  localparam logic [6:0] SEL_PIN_HIGH_HI = 7'h1b;
  localparam logic [6:0] SEL_PIN_LAST    = 7'h1f;
  localparam logic [6:0] SEL_GROUND      = 7'h40;
  localparam logic [6:0] SEL_THERMAL     = 7'h42;
  localparam logic [6:0] SEL_SUPPLY_10   = 7'h44;
  localparam logic [6:0] SEL_CMP_REF     = 7'h49;

  // Input source classes driven to the analog front end.
  typedef enum logic [2:0] {
    ARW_SRC_NONE, ARW_SRC_PIN, ARW_SRC_GROUND, ARW_SRC_THERMAL, ARW_SRC_SUPPLY, ARW_SRC_CMP_REF
  } arw_src_e;

  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ        = 100;  // Clock rate in MHz.
  localparam int SETTLE_NS      = 1000; // Least settling time after an input change.
  localparam int SETTLE_CYCLES  = (SETTLE_NS * CLK_MHZ + 999) / 1000; // Rounded up.
  localparam logic [7:0] SETTLE_COUNT = 8'(SETTLE_CYCLES);
  localparam int MAX_ACC_LOG2   = 6;    // Largest accumulation is 64 samples.
endpackage

// ==== rtl/arw_mux.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------------
// Positive input decoder: turns the select code into a source class and pin.
// ------------------------------------------------------------------------
module arw_mux
  import arw_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic [6:0] code,
  output      arw_src_e   src,
  output      logic [4:0] pin
);
  // Registered decode so the front end sees a clean, glitch-free select.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      src <= ARW_SRC_NONE;
      pin <= 5'h00;
    end else begin
      pin <= code[4:0];
      if (code >= SEL_PIN_LOW_LO && code <= SEL_PIN_LOW_HI) begin
        src <= ARW_SRC_PIN;
      end else if (code >= SEL_PIN_HIGH_LO && code <= SEL_PIN_HIGH_HI) begin
        src <= ARW_SRC_PIN;
      end else if (code == SEL_PIN_LAST) begin
        src <= ARW_SRC_PIN;
      end else begin
        // Internal sources; reserved codes connect nothing.
        case (code)
          SEL_GROUND:    src <= ARW_SRC_GROUND;
          SEL_THERMAL:   src <= ARW_SRC_THERMAL;
          SEL_SUPPLY_10: src <= ARW_SRC_SUPPLY;
          SEL_CMP_REF:   src <= ARW_SRC_CMP_REF;
          default:       src <= ARW_SRC_NONE;
        endcase
      end
    end
  end
endmodule // arw_mux

// ==== rtl/arw_regs.sv ====
`timescale 1ns/1ps
module arw_regs
  import arw_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  ADDR,          // Register byte address.
  input  wire logic [7:0]  WDATA,         // Write data.
  input  wire logic        WR,            // Write strobe, one cycle.
  input  wire logic        RD,            // Read strobe, one cycle.
  output      logic [7:0]  RDATA,         // Read data, valid the cycle after RD.
  input  wire logic [15:0] SAMPLE_DATA,   // One raw sample from the converter.
  input  wire logic        SAMPLE_VALID,  // Pulse: sample data valid.
  input  wire logic        WATCH_LATEST,  // High: comparator watches the latest sample.
  output      logic [2:0]  INPUT_SRC,     // Source class to the front end.
  output      logic [4:0]  INPUT_PIN,     // Pin number to the front end.
  output      logic        INPUT_SETTLED, // High once the selected input has settled.
  output      logic        CONV_DONE,     // Pulse: a full conversion value is ready.
  output      logic        WINDOW_INSIDE  // High when the watched value is within limits.
);
  // ----------------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------------
  logic [15:0] conversion_value;   // Summed or single result.
  logic [15:0] latest_conversion;  // Most recent single sample.
  logic [7:0]  byte_staging;       // Shared staging: high byte on reads, low byte on writes.
  logic [15:0] window_low_limit;   // Comparator low threshold.
  logic [15:0] window_high_limit;  // Comparator high threshold.
  logic [6:0]  input_select;       // Positive input select code.
  logic [2:0]  conv_mode;          // Conversion mode field.
  logic [2:0]  accumulation_count; // Log2 of samples per conversion.
  logic        left_align;         // Left align setting, status only here.
  logic [6:0]  acc_index;          // Samples summed so far.
  logic [7:0]  settle_cnt;         // Settling countdown.
  logic        final_valid;        // Conversion value holds a final sum.
  arw_src_e    src;                // Decoded source class.
  logic [4:0]  pin;                // Decoded pin number.

  // ----------------------------------------------------------------------
  // Derived controls.
  // ----------------------------------------------------------------------
  wire logic diag_mode = (conv_mode == MODE_ACC_DIAG);
  wire logic single    = (conv_mode == MODE_SINGLE8) || (conv_mode == MODE_SINGLE10);
  wire logic [6:0] acc_target = single ? 7'h01 : 7'(7'h01 << accumulation_count);
  wire logic last_sample = (acc_index + 7'h01 >= acc_target);

  // ----------------------------------------------------------------------
  // Input decoder.
  // ----------------------------------------------------------------------
  arw_mux arw_mux_i (
    .CLK  (CLK),
    .RSTN (RSTN),
    .code (input_select),
    .src  (src),
    .pin  (pin)
  );

  // Forward the decoded select to the ports from flops.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      INPUT_SRC <= 3'h0;
      INPUT_PIN <= 5'h00;
    end else begin
      INPUT_SRC <= 3'(src);
      INPUT_PIN <= pin;
    end
  end

  // ----------------------------------------------------------------------
  // Control fields written by software.
  // ----------------------------------------------------------------------
  // These fields change only on a register write; nothing in hardware touches them.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      input_select       <= 7'h00;
      conv_mode          <= 3'h0;
      accumulation_count <= 3'h0;
      left_align         <= 1'b0;
    end else if (WR) begin
      case (ADDR)
        ADDR_INPUT_SEL: input_select <= WDATA[6:0];
        ADDR_COMMAND:   conv_mode <= WDATA[MODE_LSB +: 3];
        ADDR_CTRLF: begin
          // Reserved counts above 64 samples are clamped to 64.
          accumulation_count <= (WDATA[2:0] > 3'(MAX_ACC_LOG2)) ? 3'(MAX_ACC_LOG2) : WDATA[2:0];
          left_align         <= WDATA[LEFT_ALIGN_BIT];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Settling timer: restarts on every select write.
  // ----------------------------------------------------------------------
  // Rewriting the same code still restarts the span, which is the safe side.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      settle_cnt    <= 8'h00;
      INPUT_SETTLED <= 1'b1;
    end else if (WR && ADDR == ADDR_INPUT_SEL) begin
      settle_cnt    <= SETTLE_COUNT;
      INPUT_SETTLED <= 1'b0;
    end else if (settle_cnt != 8'h00) begin
      settle_cnt    <= settle_cnt - 8'h01;
      INPUT_SETTLED <= (settle_cnt == 8'h01);
    end
  end

  // ----------------------------------------------------------------------
  // Shared staging byte: low-byte reads park the high byte, low-byte
  // writes park the low byte; high-byte writes commit both at once, the conversion value's only in diagnostics mode.
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      byte_staging <= RESET_BYTE;
    end else if (WR) begin
      case (ADDR)
        ADDR_STAGING, ADDR_CONV_L, ADDR_LATEST_L,
        ADDR_WLOW_L, ADDR_WHIGH_L: byte_staging <= WDATA;
        default: ;
      endcase
    end else if (RD) begin
      case (ADDR)
        ADDR_CONV_L:   byte_staging <= conversion_value[15:8];
        ADDR_LATEST_L: byte_staging <= latest_conversion[15:8];
        ADDR_WLOW_L:   byte_staging <= window_low_limit[15:8];
        ADDR_WHIGH_L:  byte_staging <= window_high_limit[15:8];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Window limits, committed whole on the high-byte write.
  // ----------------------------------------------------------------------
  // The comparator never sees a half-written limit, because both bytes land in one edge.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      window_low_limit  <= RESET_WORD;
      window_high_limit <= RESET_WORD;
    end else if (WR && ADDR == ADDR_WLOW_H) begin
      window_low_limit  <= {WDATA, byte_staging};
    end else if (WR && ADDR == ADDR_WHIGH_H) begin
      window_high_limit <= {WDATA, byte_staging};
    end
  end

  // ----------------------------------------------------------------------
  // Latest sample: every raw sample lands here; software may also write.
  // ----------------------------------------------------------------------
  // A sample arriving in the same cycle as a software write wins over it.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      latest_conversion <= RESET_WORD;
    end else if (SAMPLE_VALID) begin
      latest_conversion <= SAMPLE_DATA;
    end else if (WR && ADDR == ADDR_LATEST_H) begin
      latest_conversion <= {WDATA, byte_staging};
    end
  end

  // ----------------------------------------------------------------------
  // Conversion value and accumulator. In diagnostics mode software may
  // load a working value that the following samples add onto.
  // ----------------------------------------------------------------------
  // A mode change that meets a sample in the same cycle drops that sample;
  // this keeps the restart simple at the cost of one lost sample.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      conversion_value <= RESET_WORD;
      acc_index        <= 7'h00;
      final_valid      <= 1'b0;
      CONV_DONE        <= 1'b0;
    end else begin
      CONV_DONE <= 1'b0;
      if (WR && ADDR == ADDR_CONV_H && diag_mode) begin
        conversion_value <= {WDATA, byte_staging};
        final_valid      <= 1'b0;
      end else if (WR && ADDR == ADDR_COMMAND && WDATA[MODE_LSB +: 3] != conv_mode) begin
        acc_index   <= 7'h00; // Mode change restarts the sum.
        final_valid <= 1'b0;
      end else if (SAMPLE_VALID) begin
        if (acc_index == 7'h00 && !diag_mode) begin
          conversion_value <= SAMPLE_DATA;
        end else begin
          conversion_value <= conversion_value + SAMPLE_DATA;
        end
        if (last_sample) begin
          acc_index   <= 7'h00;
          final_valid <= 1'b1;
          CONV_DONE   <= 1'b1;
        end else begin
          acc_index   <= acc_index + 7'h01;
          final_valid <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Window comparator. Partial sums are never compared; while the conversion
  // value is watched, the flag holds its last final verdict until the next sum completes.
  // ----------------------------------------------------------------------
  // The verdict lags the watched value by one cycle, since it is registered.
  wire logic [15:0] watched = WATCH_LATEST ? latest_conversion : conversion_value;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      WINDOW_INSIDE <= 1'b0;
    end else if (WATCH_LATEST || final_valid) begin
      WINDOW_INSIDE <= (watched >= window_low_limit) && (watched <= window_high_limit);
    end
  end

  // ----------------------------------------------------------------------
  // Read port; unmapped addresses read zero.
  // ----------------------------------------------------------------------
  // All high bytes read through staging, so a low-byte read must come first.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= RESET_BYTE;
    end else if (RD) begin
      case (ADDR)
        ADDR_INPUT_SEL: RDATA <= {1'b0, input_select};
        ADDR_COMMAND:   RDATA <= {1'b0, conv_mode, 4'h0};
        ADDR_CTRLF:     RDATA <= {3'h0, left_align, 1'b0, accumulation_count};
        ADDR_STATUS:    RDATA <= {6'h00, WINDOW_INSIDE, INPUT_SETTLED};
        ADDR_CONV_L:    RDATA <= conversion_value[7:0];
        ADDR_LATEST_L:  RDATA <= latest_conversion[7:0];
        ADDR_WLOW_L:    RDATA <= window_low_limit[7:0];
        ADDR_WHIGH_L:   RDATA <= window_high_limit[7:0];
        ADDR_CONV_H, ADDR_LATEST_H, ADDR_WLOW_H, ADDR_WHIGH_H,
        ADDR_STAGING:   RDATA <= byte_staging;
        default:        RDATA <= RESET_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  // These watch the register side only; the analog path is out of reach here.
  // Most checks name the strobe or pulse that starts them; the decode, window-hold
  // and settle-release checks start from a held select, state or count instead.
  a_high_commit: assert property (@(posedge CLK) disable iff (!RSTN)
    (WR && ADDR == ADDR_WHIGH_H) |=> window_high_limit == {$past(WDATA), $past(byte_staging)})
    else $error("high limit not committed from staging");
  a_low_commit: assert property (@(posedge CLK) disable iff (!RSTN)
    (WR && ADDR == ADDR_WLOW_H) |=> window_low_limit == {$past(WDATA), $past(byte_staging)})
    else $error("low limit not committed from staging");
  a_stage_read: assert property (@(posedge CLK) disable iff (!RSTN)
    (RD && ADDR == ADDR_CONV_L && !SAMPLE_VALID) ##1 (RD && ADDR == ADDR_CONV_H)
      |=> RDATA == conversion_value[15:8])
    else $error("high byte read not atomic");
  a_latest_load: assert property (@(posedge CLK) disable iff (!RSTN)
    SAMPLE_VALID |=> latest_conversion == $past(SAMPLE_DATA))
    else $error("latest sample not captured");
  a_diag_write: assert property (@(posedge CLK) disable iff (!RSTN)
    (WR && ADDR == ADDR_CONV_H && diag_mode) |=> conversion_value[15:8] == $past(WDATA))
    else $error("diagnostic write lost");
  a_normal_ro: assert property (@(posedge CLK) disable iff (!RSTN)
    (WR && ADDR == ADDR_CONV_H && !diag_mode && !SAMPLE_VALID) |=> $stable(conversion_value))
    else $error("conversion value written outside diagnostics");
  a_settle_time: assert property (@(posedge CLK) disable iff (!RSTN)
    (WR && ADDR == ADDR_INPUT_SEL) |=> !INPUT_SETTLED [*8])
    else $error("settled too early");
  a_stage_write: assert property (@(posedge CLK) disable iff (!RSTN)
    (WR && ADDR == ADDR_STAGING) ##1 (RD && ADDR == ADDR_STAGING) |=> RDATA == $past(WDATA, 2))
    else $error("staging byte readback wrong");
  a_pin_decode: assert property (@(posedge CLK) disable iff (!RSTN)
    (input_select == SEL_PIN_LAST) [*3] |-> INPUT_SRC == 3'(ARW_SRC_PIN))
    else $error("last pin not routed");
  a_ground_decode: assert property (@(posedge CLK) disable iff (!RSTN)
    (input_select == SEL_GROUND) [*3] |-> INPUT_SRC == 3'(ARW_SRC_GROUND))
    else $error("ground not routed");
  a_reserved_decode: assert property (@(posedge CLK) disable iff (!RSTN)
    (input_select == 7'h41) [*3] |-> INPUT_SRC == 3'(ARW_SRC_NONE))
    else $error("reserved code connected a source");
  a_window_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    (!WATCH_LATEST && !final_valid) |=> $stable(WINDOW_INSIDE))
    else $error("window flag moved on a partial sum");
  a_settle_release: assert property (@(posedge CLK) disable iff (!RSTN)
    (settle_cnt == 8'h01 && !(WR && ADDR == ADDR_INPUT_SEL)) |=> INPUT_SETTLED)
    else $error("settled flag late");
  a_stage_park: assert property (@(posedge CLK) disable iff (!RSTN)
    (WR && (ADDR == ADDR_CONV_L || ADDR == ADDR_LATEST_L || ADDR == ADDR_WLOW_L || ADDR == ADDR_WHIGH_L))
      |=> byte_staging == $past(WDATA))
    else $error("low byte not parked in staging");
endmodule // arw_regs

// ==== sim/arw_regs_bench.sv ====
`timescale 1ns/1ps
module arw_regs_bench;
  import arw_pkg::*;
  // ----------------------------------------------------------------------
  // Stimulus, counters and the design under test.
  // ----------------------------------------------------------------------
  logic        CLK, RSTN, WR, RD, SAMPLE_VALID, WATCH_LATEST;
  logic [7:0]  ADDR, WDATA, RDATA, b;
  logic [15:0] SAMPLE_DATA, v, lo, hi, sum, last, seen;
  logic [2:0]  INPUT_SRC;
  logic [4:0]  INPUT_PIN;
  logic        INPUT_SETTLED, CONV_DONE, WINDOW_INSIDE;
  integer      seed = 21;  // Fixed seed keeps every run identical.
  int          mismatches = 0, n_checks = 0, n_done = 0, d0;
  logic [7:0]  lows [4] = '{ADDR_CONV_L, ADDR_LATEST_L, ADDR_WLOW_L, ADDR_WHIGH_L}; // Low-byte offsets.

  arw_regs arw_regs_i (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_VALID(SAMPLE_VALID),
    .WATCH_LATEST(WATCH_LATEST), .INPUT_SRC(INPUT_SRC), .INPUT_PIN(INPUT_PIN),
    .INPUT_SETTLED(INPUT_SETTLED), .CONV_DONE(CONV_DONE), .WINDOW_INSIDE(WINDOW_INSIDE));

  // The clock toggles every 5 ns for a 100 MHz rate.
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Completed conversions are counted so that early or extra pulses show up.
  always @(posedge CLK) begin
    if (CONV_DONE === 1'b1) n_done++;
  end

  // ----------------------------------------------------------------------
  // Shared tasks for comparisons and bus cycles.
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // A write holds its strobe for exactly one edge; a gap edge follows.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a; WDATA <= d; WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // Read data appear in the cycle after the strobe and hold until the next read; sample there.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a; RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask

  // Sixteen-bit values always travel low byte first through staging.
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask

  // Back-to-back reads: the low byte answers while the high byte is asked for.
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    @(posedge CLK);
    ADDR <= a; RD <= 1'b1;
    @(posedge CLK);
    ADDR <= a + 8'h01;
    #1 d[7:0] = RDATA;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d[15:8] = RDATA;
  endtask

  task automatic sample(input logic [15:0] s);
    @(posedge CLK);
    SAMPLE_DATA <= s; SAMPLE_VALID <= 1'b1;
    @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
    repeat (3) @(posedge CLK);
  endtask

  // Expected source class for a select code.
  function automatic logic [2:0] exp_src(input logic [6:0] c);
    if (c <= SEL_PIN_LOW_HI || (c >= SEL_PIN_HIGH_LO && c <= SEL_PIN_HIGH_HI) || c == SEL_PIN_LAST)
      return 3'(ARW_SRC_PIN);
    case (c)
      SEL_GROUND:    return 3'(ARW_SRC_GROUND);
      SEL_THERMAL:   return 3'(ARW_SRC_THERMAL);
      SEL_SUPPLY_10: return 3'(ARW_SRC_SUPPLY);
      SEL_CMP_REF:   return 3'(ARW_SRC_CMP_REF);
      default:       return 3'(ARW_SRC_NONE);
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    RSTN = 1'b0; WR = 1'b0; RD = 1'b0; ADDR = 8'h00; WDATA = 8'h00;
    SAMPLE_DATA = 16'h0000; SAMPLE_VALID = 1'b0; WATCH_LATEST = 1'b0;
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    // Every 16-bit register and the staging byte start at zero.
    foreach (lows[k]) begin
      rd16(lows[k], v);
      check(v, RESET_WORD);
    end
    rd(ADDR_STAGING, b);
    check(16'(b), 16'(RESET_BYTE));
    // Read-write pairs; a low-byte read leaves the high byte in staging.
    for (int k = 1; k < 4; k++) begin
      lo = 16'($random(seed));
      wr16(lows[k], lo);
      rd(lows[k], b);
      rd(ADDR_STAGING, b);
      check(16'(b), 16'(lo[15:8]));
      rd16(lows[k], v);
      check(v, lo);
    end
    // Staging is directly writable; unmapped places read zero.
    @(posedge CLK);
    ADDR <= ADDR_STAGING; WDATA <= 8'ha5; WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0; RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 b = RDATA;
    check(16'(b), 16'h00a5);
    wr(8'h3f, 8'h77);
    rd(8'h3f, b);
    check(16'(b), 16'h0000);
    // Outside diagnostics the conversion value refuses software writes.
    wr(ADDR_COMMAND, 8'(MODE_SINGLE10) << MODE_LSB);
    wr16(ADDR_CONV_L, 16'hbeef);
    rd16(ADDR_CONV_L, v);
    check(v, RESET_WORD);
    wr(ADDR_COMMAND, 8'(MODE_ACC_DIAG) << MODE_LSB);
    wr16(ADDR_CONV_L, 16'h1234);
    rd16(ADDR_CONV_L, v);
    check(v, 16'h1234);
    // In diagnostics mode a sample adds onto the written working value.
    last = 16'($random(seed)) & 16'h03ff;
    sample(last);
    rd16(ADDR_CONV_L, v);
    check(v, 16'h1234 + last);
    // Left align and a reserved count, which clamps to 64 samples.
    wr(ADDR_CTRLF, 8'h17);
    rd(ADDR_CTRLF, b);
    check(16'(b), 16'h0016);
    // Every select code decodes to its source class and pin number.
    for (int c = 0; c < 128; c++) begin
      wr(ADDR_INPUT_SEL, 8'(c));
      repeat (3) @(posedge CLK);
      check(16'(INPUT_SRC), 16'(exp_src(7'(c))));
      check(16'(INPUT_PIN), 16'(c[4:0]));
    end
    // A fresh select holds off settling for the settling span.
    repeat (120) @(posedge CLK);
    wr(ADDR_INPUT_SEL, 8'(SEL_THERMAL));
    repeat (50) @(posedge CLK);
    check(16'(INPUT_SETTLED), 16'h0000);
    repeat (60) @(posedge CLK);
    check(16'(INPUT_SETTLED), 16'h0001);
    rd(ADDR_STATUS, b);
    check(16'(b[0]), 16'h0001);
    // Conversions: single samples first, then sums of four samples.
    for (int i = 0; i < 12; i++) begin
      if (i == 0) wr(ADDR_COMMAND, 8'(MODE_SINGLE10) << MODE_LSB);
      if (i == 6) begin
        wr(ADDR_CTRLF, 8'h02);
        wr(ADDR_COMMAND, 8'h02 << MODE_LSB);
      end
      @(posedge CLK);
      WATCH_LATEST <= i[0];
      lo = 16'($random(seed)) & 16'h0fff;
      hi = lo + (16'($random(seed)) & 16'h07ff);
      wr16(ADDR_WLOW_L, lo);
      wr16(ADDR_WHIGH_L, hi);
      sum = 16'h0000;
      d0 = n_done;
      for (int s = 0; s < ((i >= 6) ? 4 : 1); s++) begin
        last = 16'($random(seed)) & 16'h03ff;
        sum = sum + last;
        sample(last);
      end
      repeat (4) @(posedge CLK);
      check(16'(n_done - d0), 16'h0001);
      rd16(ADDR_CONV_L, v);
      check(v, sum);
      rd16(ADDR_LATEST_L, v);
      check(v, last);
      seen = i[0] ? last : sum;
      check(16'(WINDOW_INSIDE), 16'(lo <= seen && seen <= hi));
      rd(ADDR_STATUS, b);
      check(16'(b[1]), 16'(lo <= seen && seen <= hi));
    end
    // Corner: limits equal to the latest sample, then the low limit just above it.
    wr16(ADDR_WLOW_L, last);
    wr16(ADDR_WHIGH_L, last);
    repeat (2) @(posedge CLK);
    check(16'(WINDOW_INSIDE), 16'h0001);
    wr16(ADDR_WLOW_L, last + 16'h0001);
    repeat (2) @(posedge CLK);
    check(16'(WINDOW_INSIDE), 16'h0000);
    report_and_stop();
  end

  // A hang is cut short well past the expected run length.
  initial begin
    #500000;
    mismatches++;
    report_and_stop();
  end
endmodule // arw_regs_bench
